// [src/ncib_cfg.svh]
// Offsets, field positions, reset values and timing counts for the common interrupt and buffer register slice.
`ifndef NCIB_CFG_SVH
`define NCIB_CFG_SVH

`define NCIB_ADDR_W 16
`define NCIB_OFS_IRQ_MASK_MAIN 16'h0016
`define NCIB_OFS_RETRY_TIMEOUT_HI 16'h0017
`define NCIB_OFS_RETRY_TIMEOUT_LO 16'h0018
`define NCIB_OFS_RETRY_COUNT 16'h0019
`define NCIB_OFS_RX_SIZES 16'h001A
`define NCIB_OFS_TX_SIZES 16'h001B
`define NCIB_OFS_IRQ_EVENTS_WAKE 16'h0020
`define NCIB_OFS_IRQ_MASK_WAKE 16'h0021
`define NCIB_OFS_PPP_ECHO_PERIOD 16'h0028

`define NCIB_RST_IRQ_MASK_MAIN 8'h00
`define NCIB_RST_RETRY_TIMEOUT 16'h07D0
`define NCIB_RST_RETRY_COUNT 8'h07
`define NCIB_RST_BUF_SIZES 8'h55
`define NCIB_RST_PPP_ECHO_PERIOD 8'h28

`define NCIB_MAIN_MASK_USED 8'hEF
`define NCIB_BIT_WAKE_MAGIC 0
`define NCIB_RETRY_TIMEOUT_UNIT_US 100
`define NCIB_PPP_ECHO_UNIT_MS 25
`define NCIB_PEND_TICK_CLOCKS 4
`define NCIB_PEND_DIV_LAST 2'h3

`endif

// [src/ncib_pkg.sv]
// Types shared by the common interrupt and buffer register slice.
package ncib_pkg;

   typedef struct packed {
      logic [3:0] sock3;
      logic [3:0] sock2;
      logic [3:0] sock1;
      logic [3:0] sock0;
   } ncib_buf_kb_t;

   typedef struct packed {
      logic [15:0] count;
      logic [1:0] div;
   } ncib_timer_state_t;

   typedef struct packed {
      logic [7:0] irq_mask_main;
      logic [15:0] retry_timeout_default;
      logic [7:0] retry_count_default;
      logic [7:0] rx_buffer_sizes;
      logic [7:0] tx_buffer_sizes;
      logic wake_magic_flag;
      logic wake_mask;
      logic [7:0] ppp_echo_period;
      logic irq_low;
      logic [7:0] rdata;
   } ncib_state_t;

endpackage

// [src/ncib_pend_timer.sv]
// Interrupt pending timer: reloads on each release of the interrupt and counts down every four clocks.
`timescale 1ns/1ps
`include "ncib_cfg.svh"

module ncib_pend_timer (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic reload_i,
   input wire logic [15:0] load_value_i,
   output logic [15:0] count_o,
   output logic zero_o
);

   ncib_pkg::ncib_timer_state_t s_q;
   ncib_pkg::ncib_timer_state_t s_d;

   always_comb begin
      s_d = s_q;
      if (reload_i) begin
         s_d.count = load_value_i;
         s_d.div = 2'h0;
      end else if (s_q.count != 16'h0000) begin
         s_d.div = s_q.div + 2'h1;
         if (s_q.div == `NCIB_PEND_DIV_LAST) begin
            s_d.count = s_q.count - 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign count_o = s_q.count;
   assign zero_o = (s_q.count == 16'h0000);

endmodule // ncib_pend_timer

// [src/ncib_regs.sv]
// Common interrupt mask, wake event, retransmission default, buffer size and echo period registers.
`timescale 1ns/1ps
`include "ncib_cfg.svh"

module ncib_regs #(
   parameter int SOCKETS = 4
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [15:0] host_addr_i,
   input wire logic host_wr_i,
   input wire logic host_rd_i,
   input wire logic [7:0] host_wdata_i,
   output logic [7:0] host_rdata_o,
   input wire logic [7:0] irq_events_main_i,
   input wire logic wake_magic_event_i,
   input wire logic irq_global_enable_i,
   input wire logic [15:0] irq_pending_time_i,
   input wire logic [SOCKETS-1:0] socket_retry_count_zero_i,
   output logic [SOCKETS-1:0] socket_retry_count_load_o,
   output logic [7:0] retry_count_seed_o,
   output logic [15:0] retry_timeout_seed_o,
   output logic [7:0] irq_mask_main_o,
   output ncib_pkg::ncib_buf_kb_t rx_buf_kb_o,
   output ncib_pkg::ncib_buf_kb_t tx_buf_kb_o,
   output logic [7:0] ppp_echo_period_o,
   output logic irq_out_low_o
);

   localparam int RETRY_TIMEOUT_UNIT_NS = `NCIB_RETRY_TIMEOUT_UNIT_US * 1000;
   localparam int PPP_ECHO_UNIT_MS = `NCIB_PPP_ECHO_UNIT_MS;

   ncib_pkg::ncib_state_t s_q;
   ncib_pkg::ncib_state_t s_d;
   logic timer_zero;
   logic [15:0] timer_count;
   logic main_cause;
   logic wake_cause;
   logic timer_reload;

   // Size code 00, 01, 10, 11 selects 1, 2, 4, 8 kilobytes.
   function automatic logic [3:0] size_kb(input logic [1:0] code);
      size_kb = 4'h1 << code;
   endfunction

   function automatic logic [7:0] read_reg(input logic [15:0] addr, input ncib_pkg::ncib_state_t st);
      case (addr)
         `NCIB_OFS_IRQ_MASK_MAIN: read_reg = st.irq_mask_main;
         `NCIB_OFS_RETRY_TIMEOUT_HI: read_reg = st.retry_timeout_default[15:8];
         `NCIB_OFS_RETRY_TIMEOUT_LO: read_reg = st.retry_timeout_default[7:0];
         `NCIB_OFS_RETRY_COUNT: read_reg = st.retry_count_default;
         `NCIB_OFS_RX_SIZES: read_reg = st.rx_buffer_sizes;
         `NCIB_OFS_TX_SIZES: read_reg = st.tx_buffer_sizes;
         `NCIB_OFS_IRQ_EVENTS_WAKE: read_reg = {7'h00, st.wake_magic_flag};
         `NCIB_OFS_IRQ_MASK_WAKE: read_reg = {7'h00, st.wake_mask};
         `NCIB_OFS_PPP_ECHO_PERIOD: read_reg = st.ppp_echo_period;
         default: read_reg = 8'h00;
      endcase
   endfunction

   // Bit 4 of the main event register is reserved and is masked out even if software sets it.
   assign main_cause = |(irq_events_main_i & s_q.irq_mask_main & `NCIB_MAIN_MASK_USED);
   assign wake_cause = s_q.wake_magic_flag & s_q.wake_mask;

   always_comb begin
      s_d = s_q;
      if (host_wr_i) begin
         case (host_addr_i)
            `NCIB_OFS_IRQ_MASK_MAIN: s_d.irq_mask_main = host_wdata_i & `NCIB_MAIN_MASK_USED;
            `NCIB_OFS_RETRY_TIMEOUT_HI: s_d.retry_timeout_default[15:8] = host_wdata_i;
            `NCIB_OFS_RETRY_TIMEOUT_LO: s_d.retry_timeout_default[7:0] = host_wdata_i;
            `NCIB_OFS_RETRY_COUNT: s_d.retry_count_default = host_wdata_i;
            `NCIB_OFS_RX_SIZES: s_d.rx_buffer_sizes = host_wdata_i;
            `NCIB_OFS_TX_SIZES: s_d.tx_buffer_sizes = host_wdata_i;
            `NCIB_OFS_IRQ_EVENTS_WAKE: begin
               if (host_wdata_i[`NCIB_BIT_WAKE_MAGIC]) begin
                  s_d.wake_magic_flag = 1'b0;
               end
            end
            `NCIB_OFS_IRQ_MASK_WAKE: s_d.wake_mask = host_wdata_i[`NCIB_BIT_WAKE_MAGIC];
            `NCIB_OFS_PPP_ECHO_PERIOD: s_d.ppp_echo_period = host_wdata_i;
            default: s_d.irq_mask_main = s_q.irq_mask_main;
         endcase
      end
      // The hardware set comes after the host clear so that a packet arriving in the clearing cycle is kept.
      if (wake_magic_event_i) begin
         s_d.wake_magic_flag = 1'b1;
      end
      s_d.irq_low = irq_global_enable_i & (main_cause | wake_cause) & timer_zero;
      if (host_rd_i) begin
         s_d.rdata = read_reg(host_addr_i, s_q);
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q.irq_mask_main <= `NCIB_RST_IRQ_MASK_MAIN;
         s_q.retry_timeout_default <= `NCIB_RST_RETRY_TIMEOUT;
         s_q.retry_count_default <= `NCIB_RST_RETRY_COUNT;
         s_q.rx_buffer_sizes <= `NCIB_RST_BUF_SIZES;
         s_q.tx_buffer_sizes <= `NCIB_RST_BUF_SIZES;
         s_q.wake_magic_flag <= 1'b0;
         s_q.wake_mask <= 1'b0;
         s_q.ppp_echo_period <= `NCIB_RST_PPP_ECHO_PERIOD;
         s_q.irq_low <= 1'b0;
         s_q.rdata <= 8'h00;
      end else begin
         s_q <= s_d;
      end
   end

   // The timer restarts only on a release, so it stays at zero for as long as the output is held low.
   assign timer_reload = s_q.irq_low & ~s_d.irq_low;

   ncib_pend_timer u_pend_timer (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .reload_i(timer_reload),
      .load_value_i(irq_pending_time_i),
      .count_o(timer_count),
      .zero_o(timer_zero)
   );

   // Sockets own their counters; this slice only flags the reload and supplies the seeds.
   assign socket_retry_count_load_o = socket_retry_count_zero_i;
   assign retry_count_seed_o = s_q.retry_count_default;
   assign retry_timeout_seed_o = s_q.retry_timeout_default;
   assign irq_mask_main_o = s_q.irq_mask_main;
   assign ppp_echo_period_o = s_q.ppp_echo_period;
   assign rx_buf_kb_o = {size_kb(s_q.rx_buffer_sizes[7:6]), size_kb(s_q.rx_buffer_sizes[5:4]),
                         size_kb(s_q.rx_buffer_sizes[3:2]), size_kb(s_q.rx_buffer_sizes[1:0])};
   assign tx_buf_kb_o = {size_kb(s_q.tx_buffer_sizes[7:6]), size_kb(s_q.tx_buffer_sizes[5:4]),
                         size_kb(s_q.tx_buffer_sizes[3:2]), size_kb(s_q.tx_buffer_sizes[1:0])};
   assign host_rdata_o = s_q.rdata;
   assign irq_out_low_o = ~s_q.irq_low;

   // All checks sample on the system clock and stand down while reset is held.
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   // Release conditions: any one of them keeps the output high on the next edge.
   AST_IEN_OFF: assert property (!irq_global_enable_i |=> irq_out_low_o)
      else $error("interrupt asserted while global enable was low");

   AST_MASKED_QUIET: assert property (((irq_events_main_i & s_q.irq_mask_main) == 8'h00)
      && !wake_cause |=> irq_out_low_o)
      else $error("interrupt asserted with every event masked");

   AST_TIMER_BLOCKS: assert property (!timer_zero |=> irq_out_low_o)
      else $error("interrupt asserted while the pending timer ran");

   AST_WAKE_MASK_OFF: assert property (!s_q.wake_mask && !main_cause |=> irq_out_low_o)
      else $error("interrupt asserted with wake masked and no main cause");

   // A reserved event on bit 4 has no mask partner, so on its own it must never fire.
   AST_SAME_BIT: assert property (irq_events_main_i == 8'h10 && !wake_cause |=> irq_out_low_o)
      else $error("event on a bit without a mask asserted interrupt");

   // Firing conditions: an unmasked source pulls the output low once the timer is idle and the global enable is high.
   AST_CONFLICT_FIRES: assert property (irq_global_enable_i && timer_zero && irq_events_main_i[7]
      && s_q.irq_mask_main[7] |=> !irq_out_low_o)
      else $error("unmasked conflict event did not assert interrupt");

   AST_PORT_UNREACHABLE_FLAG_FIRES: assert property (irq_global_enable_i && timer_zero && irq_events_main_i[6]
      && s_q.irq_mask_main[6] |=> !irq_out_low_o)
      else $error("unmasked unreachable event did not assert interrupt");

   AST_PPP_END_FIRES: assert property (irq_global_enable_i && timer_zero && irq_events_main_i[5]
      && s_q.irq_mask_main[5] |=> !irq_out_low_o)
      else $error("unmasked session end event did not assert interrupt");

   AST_SOCKET_FIRES: assert property (irq_global_enable_i && timer_zero
      && (|(irq_events_main_i[3:0] & s_q.irq_mask_main[3:0])) |=> !irq_out_low_o)
      else $error("unmasked socket event did not assert interrupt");

   AST_WAKE_FIRES: assert property (irq_global_enable_i && timer_zero && wake_cause |=> !irq_out_low_o)
      else $error("unmasked wake event did not assert interrupt");

   // Wake flag: the hardware set wins over a host clear that lands in the same cycle.
   AST_WAKE_SET: assert property (wake_magic_event_i |=> s_q.wake_magic_flag)
      else $error("wake event did not set flag");

   AST_SET_WINS: assert property (wake_magic_event_i && host_wr_i
      && host_addr_i == `NCIB_OFS_IRQ_EVENTS_WAKE && host_wdata_i[`NCIB_BIT_WAKE_MAGIC] |=> s_q.wake_magic_flag)
      else $error("host clear beat a coincident wake event");

   AST_W1C: assert property (host_wr_i && host_addr_i == `NCIB_OFS_IRQ_EVENTS_WAKE
      && host_wdata_i[`NCIB_BIT_WAKE_MAGIC] && !wake_magic_event_i
      |=> !s_q.wake_magic_flag ##1 (irq_out_low_o || $past(main_cause)))
      else $error("write one did not clear wake flag and release interrupt");

   AST_W0_KEEP: assert property (host_wr_i && host_addr_i == `NCIB_OFS_IRQ_EVENTS_WAKE
      && !host_wdata_i[`NCIB_BIT_WAKE_MAGIC] && s_q.wake_magic_flag |=> s_q.wake_magic_flag)
      else $error("write zero disturbed wake flag");

   AST_WAKE_CLEAR_ONLY: assert property (s_q.wake_magic_flag && !(host_wr_i
      && host_addr_i == `NCIB_OFS_IRQ_EVENTS_WAKE && host_wdata_i[`NCIB_BIT_WAKE_MAGIC]) |=> s_q.wake_magic_flag)
      else $error("wake flag fell without a write of one");

   AST_MASK_WRITE: assert property (host_wr_i && host_addr_i == `NCIB_OFS_IRQ_MASK_WAKE
      |=> s_q.wake_mask == $past(host_wdata_i[`NCIB_BIT_WAKE_MAGIC]))
      else $error("wake mask did not take the written bit");

   AST_MASK_RELEASE: assert property (host_wr_i && host_addr_i == `NCIB_OFS_IRQ_MASK_WAKE
      && !host_wdata_i[`NCIB_BIT_WAKE_MAGIC] |-> ##2 (irq_out_low_o || $past(main_cause)))
      else $error("clearing the wake mask did not release interrupt");

   // Pending timer: loaded on every release, then one step per four clocks down to zero.
   AST_RELOAD: assert property (timer_reload |=> timer_count == $past(irq_pending_time_i))
      else $error("pending timer not reloaded on release");

   AST_DIV_RESTART: assert property (timer_reload |=> u_pend_timer.s_q.div == 2'h0)
      else $error("pending timer prescaler not restarted on release");

   AST_TICK_FOUR: assert property ((!timer_reload && timer_count > 16'h0001 && !s_q.irq_low
      && u_pend_timer.s_q.div == 2'h0) ##0 (!timer_reload) [*4]
      |=> timer_count == $past(timer_count, 4) - 16'h0001)
      else $error("pending timer did not step once per four clocks");

   AST_ZERO_HOLDS: assert property (timer_zero && !timer_reload |=> timer_zero)
      else $error("idle pending timer moved without a release");

   // Register writes: bytes land where the address says and the seeds follow at once.
   AST_MAIN_MASK_WRITE: assert property (host_wr_i && host_addr_i == `NCIB_OFS_IRQ_MASK_MAIN
      |=> irq_mask_main_o[7:5] == $past(host_wdata_i[7:5]) && irq_mask_main_o[3:0] == $past(host_wdata_i[3:0]))
      else $error("main mask did not take the written bits");

   AST_HIGH_BYTE: assert property (host_wr_i && host_addr_i == `NCIB_OFS_RETRY_TIMEOUT_HI
      |=> retry_timeout_seed_o[15:8] == $past(host_wdata_i))
      else $error("high byte of timeout not at lower address");

   AST_LOW_BYTE: assert property (host_wr_i && host_addr_i == `NCIB_OFS_RETRY_TIMEOUT_LO
      |=> retry_timeout_seed_o[7:0] == $past(host_wdata_i))
      else $error("low byte of timeout not at upper address");

   AST_TIMEOUT_HOLDS: assert property (!(host_wr_i && (host_addr_i == `NCIB_OFS_RETRY_TIMEOUT_HI
      || host_addr_i == `NCIB_OFS_RETRY_TIMEOUT_LO)) |=> $stable(retry_timeout_seed_o))
      else $error("timeout seed changed without a write");

   AST_COUNT_WRITE: assert property (host_wr_i && host_addr_i == `NCIB_OFS_RETRY_COUNT
      |=> retry_count_seed_o == $past(host_wdata_i))
      else $error("retry count seed did not take the written byte");

   AST_COUNT_HOLDS: assert property (!(host_wr_i && host_addr_i == `NCIB_OFS_RETRY_COUNT)
      |=> $stable(retry_count_seed_o))
      else $error("retry count seed changed without a write");

   AST_RETRY_LOAD: assert property (socket_retry_count_load_o == socket_retry_count_zero_i)
      else $error("socket reload request does not follow the zero count");

   AST_RX_SIZE: assert property (host_wr_i && host_addr_i == `NCIB_OFS_RX_SIZES
      && host_wdata_i[7:6] == 2'h2 |=> rx_buf_kb_o.sock3 == 4'h4)
      else $error("socket 3 receive size code did not give 4 KB");

   AST_TX_SIZE: assert property (host_wr_i && host_addr_i == `NCIB_OFS_TX_SIZES
      && host_wdata_i[1:0] == 2'h2 |=> tx_buf_kb_o.sock0 == 4'h4)
      else $error("socket 0 transmit size code did not give 4 KB");

   AST_RX_ONEHOT: assert property ($onehot(rx_buf_kb_o.sock3) && $onehot(rx_buf_kb_o.sock2)
      && $onehot(rx_buf_kb_o.sock1) && $onehot(rx_buf_kb_o.sock0))
      else $error("receive size is not a single power of two");

   AST_TX_ONEHOT: assert property ($onehot(tx_buf_kb_o.sock3) && $onehot(tx_buf_kb_o.sock2)
      && $onehot(tx_buf_kb_o.sock1) && $onehot(tx_buf_kb_o.sock0))
      else $error("transmit size is not a single power of two");

   AST_ECHO_WRITE: assert property (host_wr_i && host_addr_i == `NCIB_OFS_PPP_ECHO_PERIOD
      |=> ppp_echo_period_o == $past(host_wdata_i))
      else $error("echo period did not take the written byte");

   AST_ECHO_HOLDS: assert property (!(host_wr_i && host_addr_i == `NCIB_OFS_PPP_ECHO_PERIOD)
      |=> $stable(ppp_echo_period_o))
      else $error("echo period changed without a write");

   // Reserved bits: stored as zero and read back as zero.
   AST_MAIN_MASK_RSVD: assert property (!irq_mask_main_o[4])
      else $error("reserved main mask bit was stored");

   AST_RESERVED_ZERO: assert property (host_rd_i && host_addr_i == `NCIB_OFS_IRQ_MASK_WAKE
      |=> host_rdata_o[7:1] == 7'h00)
      else $error("reserved bits read nonzero");

   AST_EVENTS_RSVD: assert property (host_rd_i && host_addr_i == `NCIB_OFS_IRQ_EVENTS_WAKE
      |=> host_rdata_o[7:1] == 7'h00)
      else $error("reserved wake event bits read nonzero");

endmodule // ncib_regs

// [tb/ncib_host_model.sv]
// Host microcontroller model that drives the byte-wide register bus of the slice.
`timescale 1ns/1ps

module ncib_host_model (
   input wire logic clk_sys_i,
   output logic [15:0] host_addr_o,
   output logic host_wr_o,
   output logic host_rd_o,
   output logic [7:0] host_wdata_o,
   input wire logic [7:0] host_rdata_i
);
   initial begin
      host_addr_o = 16'h0000;
      host_wr_o = 1'b0;
      host_rd_o = 1'b0;
      host_wdata_o = 8'h00;
   end

   // One byte per strobe, raised just after an edge and dropped just after the edge that takes it.
   // Released address and data lines show the inverse of their last value, so a late sample cannot pass by luck.
   task automatic xfer(input logic [15:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
      @(posedge clk_sys_i);
      #2;
      host_addr_o = a;
      host_wdata_o = d;
      host_wr_o = w;
      host_rd_o = !w;
      @(posedge clk_sys_i);
      #2;
      host_wr_o = 1'b0;
      host_rd_o = 1'b0;
      host_addr_o = ~a;
      host_wdata_o = ~d;
      q = host_rdata_i;
   endtask
endmodule // ncib_host_model

// [tb/tb_net_common_irq_buffer_cfg.sv]
// Self-checking bench for the common interrupt and buffer register slice.
`timescale 1ns/1ps

module tb_net_common_irq_buffer_cfg;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] rst;
      logic [7:0] wd;
      logic [7:0] rd;
   } ncib_row_t;
   // Size rows keep each direction at 8 KB in total, so code 11 cannot appear with four sockets.
   ncib_row_t rows [10] = '{'{16'h0016, 8'h00, 8'hFF, 8'hEF}, '{16'h0017, 8'h07, 8'h13, 8'h13},
      '{16'h0018, 8'hD0, 8'h88, 8'h88}, '{16'h0019, 8'h07, 8'h00, 8'h00}, '{16'h001A, 8'h55, 8'h90, 8'h90},
      '{16'h001B, 8'h55, 8'h06, 8'h06}, '{16'h0020, 8'h00, 8'hFF, 8'h00}, '{16'h0021, 8'h00, 8'hFF, 8'h01},
      '{16'h0028, 8'h28, 8'hC8, 8'hC8}, '{16'h0015, 8'h00, 8'hFF, 8'h00}};
   logic clk_sys_i, rst_n_i, host_wr, host_rd, wake, gen, irq;
   logic [15:0] host_addr, ptime, rts;
   logic [7:0] host_wdata, host_rdata, ev, rcs, mask, echo, q;
   logic [3:0] zero, load;
   ncib_pkg::ncib_buf_kb_t rxkb, txkb;
   int bad_count = 0;
   int total_checks = 0;

   ncib_host_model host (.clk_sys_i(clk_sys_i), .host_addr_o(host_addr), .host_wr_o(host_wr),
      .host_rd_o(host_rd), .host_wdata_o(host_wdata), .host_rdata_i(host_rdata));
   ncib_regs #(.SOCKETS(4)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .host_addr_i(host_addr),
      .host_wr_i(host_wr), .host_rd_i(host_rd), .host_wdata_i(host_wdata), .host_rdata_o(host_rdata),
      .irq_events_main_i(ev), .wake_magic_event_i(wake), .irq_global_enable_i(gen),
      .irq_pending_time_i(ptime), .socket_retry_count_zero_i(zero), .socket_retry_count_load_o(load),
      .retry_count_seed_o(rcs), .retry_timeout_seed_o(rts), .irq_mask_main_o(mask), .rx_buf_kb_o(rxkb),
      .tx_buf_kb_o(txkb), .ppp_echo_period_o(echo), .irq_out_low_o(irq));

   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   task automatic summarize();
      if (bad_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #2;
   endtask

   task automatic wait_irq(input logic lvl, input int lim);
      int n;
      n = 0;
      while (irq !== lvl && n < lim) begin
         tick(1);
         n++;
      end
      chk(irq, lvl);
      if (irq !== lvl)
         summarize();
   endtask

   initial begin
      rst_n_i = 1'b0;
      ev = 8'h00;
      wake = 1'b0;
      gen = 1'b1;
      ptime = 16'h0000;
      zero = 4'h0;
      tick(4);
      rst_n_i = 1'b1;
      chk(rts, 16'h07D0);
      chk({rxkb, txkb}, 32'h22222222);
      chk({echo, mask, rcs}, 24'h280007);
      chk(irq, 1'b1);
      foreach (rows[i]) begin
         host.xfer(rows[i].addr, 8'h00, 1'b0, q);
         chk(q, rows[i].rst);
         host.xfer(rows[i].addr, rows[i].wd, 1'b1, q);
         host.xfer(rows[i].addr, 8'h00, 1'b0, q);
         chk(q, rows[i].rd);
      end
      chk(rts, 16'h1388);
      chk({rxkb, txkb}, 32'h42111124);
      chk({echo, mask, rcs}, 24'hC8EF00);
      host.xfer(16'h0021, 8'h00, 1'b1, q);
      for (int i = 0; i < 8; i++) begin
         host.xfer(16'h0016, 8'h01 << i, 1'b1, q);
         ev = ~(8'h01 << i);
         tick(3);
         chk(irq, 1'b1);
         ev = 8'h01 << i;
         tick(3);
         chk(irq, i == 4);
         ev = 8'h00;
         tick(3);
      end
      gen = 1'b0;
      ev = 8'h80;
      tick(3);
      chk(irq, 1'b1);
      gen = 1'b1;
      tick(3);
      chk(irq, 1'b0);
      ev = 8'h00;
      host.xfer(16'h0021, 8'h01, 1'b1, q);
      wake = 1'b1;
      tick(1);
      wake = 1'b0;
      wait_irq(1'b0, 4);
      host.xfer(16'h0020, 8'h00, 1'b1, q);
      host.xfer(16'h0020, 8'h00, 1'b0, q);
      chk(q, 8'h01);
      ptime = 16'h0005;
      host.xfer(16'h0020, 8'h01, 1'b1, q);
      tick(1);
      chk(irq, 1'b1);
      wake = 1'b1;
      tick(1);
      wake = 1'b0;
      tick(10);
      chk(irq, 1'b1);
      wait_irq(1'b0, 20);
      host.xfer(16'h0021, 8'h00, 1'b1, q);
      tick(1);
      chk(irq, 1'b1);
      host.xfer(16'h0020, 8'h01, 1'b1, q);
      host.xfer(16'h0020, 8'h00, 1'b0, q);
      chk(q, 8'h00);
      // The wake pulse is timed to meet the write-one clear at the same sampling edge.
      fork
         host.xfer(16'h0020, 8'h01, 1'b1, q);
         begin
            tick(1);
            wake = 1'b1;
            tick(1);
            wake = 1'b0;
         end
      join
      host.xfer(16'h0020, 8'h00, 1'b0, q);
      chk(q, 8'h01);
      zero = 4'hA;
      tick(1);
      chk(load, 4'hA);
      zero = 4'h5;
      tick(1);
      chk(load, 4'h5);
      rst_n_i = 1'b0;
      tick(1);
      chk({rts, mask}, 24'h07D000);
      rst_n_i = 1'b1;
      tick(2);
      chk(irq, 1'b1);
      host.xfer(16'h0020, 8'h00, 1'b0, q);
      chk(q, 8'h00);
      summarize();
   end
endmodule // tb_net_common_irq_buffer_cfg
